// ===== rtl/xfer_decoder_defs.vh
`ifndef XFER_DECODER_DEFS_VH
`define XFER_DECODER_DEFS_VH

// First-byte opcode patterns, upper seven bits (size flag excluded)
`define OPC7_REG_TO_RM      7'h44
`define OPC7_RM_TO_REG      7'h45
`define OPC7_SWAP           7'h43
`define OPC7_PORT_IN_FIXED  7'h72
`define OPC7_PORT_OUT_FIXED 7'h73

// Full-byte opcodes
`define OPC_RM_TO_SEG       8'h8e
`define OPC_SEG_TO_RM       8'h8c
`define OPC_PUSH_MEM        8'hff
`define OPC_POP_RM          8'h8f
`define OPC_EA_LOAD         8'h8d
`define OPC_FAR_DS          8'hc5
`define OPC_FAR_ES          8'hc4
`define OPC_TABLE_LOOKUP    8'hd7
`define OPC_FLAGS_LOAD      8'h9f
`define OPC_FLAGS_STORE     8'h9e

// Addressing-form byte fields
`define MODRM_MOD_HI        7
`define MODRM_MOD_LO        6
`define MODRM_REG_HI        5
`define MODRM_REG_LO        3
`define MODRM_RM_HI         2
`define MODRM_RM_LO         0
`define MOD_REGISTER        2'h3
`define MOD_NO_DISP         2'h0
`define MOD_DISP8           2'h1
`define RM_DIRECT           3'h6
`define SUB_PUSH_MEM        3'h6
`define SUB_POP_RM          3'h0

// Operation class codes
`define CLS_W               5
`define CLS_NONE            5'h00
`define CLS_REG_TO_RM       5'h01
`define CLS_RM_TO_REG       5'h02
`define CLS_RM_TO_SEG       5'h03
`define CLS_SEG_TO_RM       5'h04
`define CLS_PUSH_MEM        5'h05
`define CLS_POP_RM          5'h06
`define CLS_SWAP            5'h07
`define CLS_PORT_IN         5'h08
`define CLS_PORT_OUT        5'h09
`define CLS_EA_LOAD         5'h0a
`define CLS_FAR_DS          5'h0b
`define CLS_FAR_ES          5'h0c
`define CLS_TABLE_LOOKUP    5'h0d
`define CLS_FLAGS_LOAD      5'h0e
`define CLS_FLAGS_STORE     5'h0f

`endif

// ===== rtl/first_byte_classifier.v
`timescale 1ns/1ps
`default_nettype none
`include "xfer_decoder_defs.vh"

module first_byte_classifier
(
  input  wire [7:0]         opcode,
  output reg  [`CLS_W-1:0]  op_class,
  output reg                needs_modrm,
  output reg                needs_port,
  output wire               word_size
);

  // Size flag sits in bit 0 of every size-carrying opcode
  assign word_size = opcode[0];

  // Map the first byte onto its operation class and trailing-byte needs
  always @*
  begin
    op_class    = `CLS_NONE;
    needs_modrm = 1'b0;
    needs_port  = 1'b0;
    case (opcode[7:1])
      `OPC7_REG_TO_RM:      begin op_class = `CLS_REG_TO_RM; needs_modrm = 1'b1; end
      `OPC7_RM_TO_REG:      begin op_class = `CLS_RM_TO_REG; needs_modrm = 1'b1; end
      `OPC7_SWAP:           begin op_class = `CLS_SWAP;      needs_modrm = 1'b1; end
      `OPC7_PORT_IN_FIXED:  begin op_class = `CLS_PORT_IN;   needs_port  = 1'b1; end
      `OPC7_PORT_OUT_FIXED: begin op_class = `CLS_PORT_OUT;  needs_port  = 1'b1; end
      default:
      begin
        case (opcode)
          `OPC_RM_TO_SEG:    begin op_class = `CLS_RM_TO_SEG; needs_modrm = 1'b1; end
          `OPC_SEG_TO_RM:    begin op_class = `CLS_SEG_TO_RM; needs_modrm = 1'b1; end
          `OPC_PUSH_MEM:     begin op_class = `CLS_PUSH_MEM;  needs_modrm = 1'b1; end
          `OPC_POP_RM:       begin op_class = `CLS_POP_RM;    needs_modrm = 1'b1; end
          `OPC_EA_LOAD:      begin op_class = `CLS_EA_LOAD;   needs_modrm = 1'b1; end
          `OPC_FAR_DS:       begin op_class = `CLS_FAR_DS;    needs_modrm = 1'b1; end
          `OPC_FAR_ES:       begin op_class = `CLS_FAR_ES;    needs_modrm = 1'b1; end
          `OPC_TABLE_LOOKUP: op_class = `CLS_TABLE_LOOKUP;
          `OPC_FLAGS_LOAD:   op_class = `CLS_FLAGS_LOAD;
          `OPC_FLAGS_STORE:  op_class = `CLS_FLAGS_STORE;
          default:           op_class = `CLS_NONE;
        endcase
      end
    endcase
  end

endmodule // first_byte_classifier

`default_nettype wire

// ===== rtl/modrm_checker.v
`timescale 1ns/1ps
`default_nettype none
`include "xfer_decoder_defs.vh"

module modrm_checker
(
  input  wire [`CLS_W-1:0]  op_class,
  input  wire [7:0]         modrm,
  output reg                form_ok,
  output reg  [1:0]         disp_bytes,
  output wire               rm_is_reg
);

  wire [1:0] mode;
  wire [2:0] mid;
  wire [2:0] rm;

  assign mode      = modrm[`MODRM_MOD_HI:`MODRM_MOD_LO];
  assign mid       = modrm[`MODRM_REG_HI:`MODRM_REG_LO];
  assign rm        = modrm[`MODRM_RM_HI:`MODRM_RM_LO];
  assign rm_is_reg = (mode == `MOD_REGISTER);

  // Displacement length follows the addressing form; register form has none
  always @*
  begin
    case (mode)
      `MOD_REGISTER: disp_bytes = 2'h0;
      `MOD_DISP8:    disp_bytes = 2'h1;
      `MOD_NO_DISP:  disp_bytes = (rm == `RM_DIRECT) ? 2'h2 : 2'h0;
      default:       disp_bytes = 2'h2;
    endcase
  end

  // Per-class legality of the addressing-form byte
  always @*
  begin
    case (op_class)
      `CLS_RM_TO_SEG: form_ok = ~mid[2];
      `CLS_SEG_TO_RM: form_ok = ~mid[2];
      `CLS_PUSH_MEM:  form_ok = (mid == `SUB_PUSH_MEM);
      `CLS_POP_RM:    form_ok = (mid == `SUB_POP_RM);
      `CLS_EA_LOAD:   form_ok = ~rm_is_reg;
      `CLS_FAR_DS:    form_ok = ~rm_is_reg;
      `CLS_FAR_ES:    form_ok = ~rm_is_reg;
      default:        form_ok = 1'b1;
    endcase
  end

endmodule // modrm_checker

`default_nettype wire

// ===== rtl/data_transfer_opcode_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "xfer_decoder_defs.vh"

module data_transfer_opcode_decoder
(
  input  wire               ref_clk,
  input  wire               srst,
  input  wire               byte_valid,
  input  wire [7:0]         byte_data,
  output wire               byte_ready,
  output reg                dec_valid,
  output reg  [`CLS_W-1:0]  dec_class,
  output reg                dec_word,
  output reg                dec_illegal,
  output reg  [1:0]         dec_mode,
  output reg  [2:0]         dec_reg,
  output reg  [2:0]         dec_rm,
  output reg                dec_rm_is_reg,
  output reg  [1:0]         dec_disp_bytes,
  output reg  [7:0]         dec_port,
  output reg                transfer_op,
  output reg                swap_op,
  output reg                table_lookup_op,
  output reg                effective_address_load_op,
  output reg                far_pointer_data_seg_op,
  output reg                far_pointer_extra_seg_op,
  output reg                flags_high_byte_load_op,
  output reg                flags_high_byte_store_op
);

  // One-hot states of the byte collector
  localparam [2:0] ST_OPCODE = 3'h1;
  localparam [2:0] ST_MODRM  = 3'h2;
  localparam [2:0] ST_PORT   = 3'h4;

  reg  [2:0]         state;
  reg  [2:0]         next_state;
  reg  [7:0]         opcode;
  reg  [7:0]         next_opcode;
  reg  [`CLS_W-1:0]  class_sel;
  wire [7:0]         cls_in;
  wire [`CLS_W-1:0]  op_class;
  wire               needs_modrm;
  wire               needs_port;
  wire               word_size;
  wire               form_ok;
  wire [1:0]         disp_bytes;
  wire               rm_is_reg;
  wire               finish;

  // Classify the live byte while idle, the held opcode afterwards
  assign cls_in     = (state == ST_OPCODE) ? byte_data : opcode;
  assign byte_ready = 1'b1;

  first_byte_classifier u_classify
  (
    .opcode      (cls_in),
    .op_class    (op_class),
    .needs_modrm (needs_modrm),
    .needs_port  (needs_port),
    .word_size   (word_size)
  );

  modrm_checker u_form
  (
    .op_class   (op_class),
    .modrm      (byte_data),
    .form_ok    (form_ok),
    .disp_bytes (disp_bytes),
    .rm_is_reg  (rm_is_reg)
  );

  // Sequence opcode, then addressing-form or port byte
  always @*
  begin
    next_state  = state;
    next_opcode = opcode;
    case (state)
      ST_OPCODE:
      begin
        if (byte_valid && needs_modrm)
        begin
          next_state  = ST_MODRM;
          next_opcode = byte_data;
        end
        else if (byte_valid && needs_port)
        begin
          next_state  = ST_PORT;
          next_opcode = byte_data;
        end
      end
      ST_MODRM:
        if (byte_valid)
          next_state = ST_OPCODE;
      ST_PORT:
        if (byte_valid)
          next_state = ST_OPCODE;
      default:
        next_state = ST_OPCODE;
    endcase
  end

  // A decode result is produced on the final byte of each instruction
  assign finish = byte_valid &&
                  (((state == ST_OPCODE) && !needs_modrm && !needs_port) ||
                   (state == ST_MODRM) || (state == ST_PORT));

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      state   <= ST_OPCODE;
      opcode  <= 8'h00;
    end
    else
    begin
      state   <= next_state;
      opcode  <= next_opcode;
    end
  end

  // Pass the operation class through unchanged for the named-operation flags
  always @*
  begin
    class_sel = op_class;
  end

  // Register decoded fields on the instruction's last byte
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      dec_valid                 <= 1'b0;
      dec_class                 <= `CLS_NONE;
      dec_word                  <= 1'b0;
      dec_illegal               <= 1'b0;
      dec_mode                  <= 2'h0;
      dec_reg                   <= 3'h0;
      dec_rm                    <= 3'h0;
      dec_rm_is_reg             <= 1'b0;
      dec_disp_bytes            <= 2'h0;
      dec_port                  <= 8'h00;
      transfer_op               <= 1'b0;
      swap_op                   <= 1'b0;
      table_lookup_op           <= 1'b0;
      effective_address_load_op <= 1'b0;
      far_pointer_data_seg_op   <= 1'b0;
      far_pointer_extra_seg_op  <= 1'b0;
      flags_high_byte_load_op   <= 1'b0;
      flags_high_byte_store_op  <= 1'b0;
    end
    else
    begin
      dec_valid <= finish;
      if (finish)
      begin
        dec_class   <= class_sel;
        dec_word    <= word_size;
        dec_illegal <= (class_sel == `CLS_NONE) ||
                       ((state == ST_MODRM) && !form_ok);
        if (state == ST_MODRM)
        begin
          dec_mode       <= byte_data[`MODRM_MOD_HI:`MODRM_MOD_LO];
          dec_reg        <= byte_data[`MODRM_REG_HI:`MODRM_REG_LO];
          dec_rm         <= byte_data[`MODRM_RM_HI:`MODRM_RM_LO];
          dec_rm_is_reg  <= rm_is_reg;
          dec_disp_bytes <= disp_bytes;
        end
        else
        begin
          dec_mode       <= 2'h0;
          dec_reg        <= 3'h0;
          dec_rm         <= 3'h0;
          dec_rm_is_reg  <= 1'b0;
          dec_disp_bytes <= 2'h0;
        end
        dec_port <= (state == ST_PORT) ? byte_data : 8'h00;
        transfer_op <= (class_sel == `CLS_REG_TO_RM) || (class_sel == `CLS_RM_TO_REG) ||
                       (class_sel == `CLS_RM_TO_SEG) || (class_sel == `CLS_SEG_TO_RM);
        swap_op                   <= (class_sel == `CLS_SWAP);
        table_lookup_op           <= (class_sel == `CLS_TABLE_LOOKUP);
        effective_address_load_op <= (class_sel == `CLS_EA_LOAD);
        far_pointer_data_seg_op   <= (class_sel == `CLS_FAR_DS);
        far_pointer_extra_seg_op  <= (class_sel == `CLS_FAR_ES);
        flags_high_byte_load_op   <= (class_sel == `CLS_FLAGS_LOAD);
        flags_high_byte_store_op  <= (class_sel == `CLS_FLAGS_STORE);
      end
    end
  end

endmodule // data_transfer_opcode_decoder

`default_nettype wire

// ===== verification/xfer_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "xfer_decoder_defs.vh"

module xfer_decoder_properties
(
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire logic              byte_valid,
  input wire logic [7:0]        byte_data,
  input wire logic              byte_ready,
  input wire logic              dec_valid,
  input wire logic [`CLS_W-1:0] dec_class,
  input wire logic              dec_word,
  input wire logic              dec_illegal,
  input wire logic [1:0]        dec_mode,
  input wire logic [2:0]        dec_reg,
  input wire logic [2:0]        dec_rm,
  input wire logic              dec_rm_is_reg,
  input wire logic [1:0]        dec_disp_bytes,
  input wire logic [7:0]        dec_port,
  input wire logic              table_lookup_op,
  input wire logic              flags_high_byte_load_op,
  input wire logic              flags_high_byte_store_op
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic       need_more;
  logic [7:0] first;

  // Follow which byte of an instruction arrives next
  always_ff @(posedge ref_clk)
    if (srst)
      need_more <= 1'b0;
    else if (byte_valid)
    begin
      need_more <= !need_more && byte_data inside {[8'h86:8'h8f], 8'hff, 8'hc4, 8'hc5, [8'he4:8'he7]};
      first     <= byte_data;
    end

  // Second byte of a pair, and a given first byte
  sequence s_second;
    byte_valid && need_more;
  endsequence
  sequence s_first(logic [7:0] op);
    byte_valid && !need_more && byte_data == op;
  endsequence

  a_ready_high: assert property (byte_ready)
    else $error("ready dropped");
  a_result_cause: assert property (dec_valid |-> $past(byte_valid))
    else $error("result without a byte");
  a_lookup_decode: assert property (s_first(8'hd7) |=> dec_valid && table_lookup_op)
    else $error("lookup not decoded");
  a_flags_load: assert property (s_first(8'h9f) |=> flags_high_byte_load_op && !flags_high_byte_store_op)
    else $error("flag load not decoded");
  a_flags_store: assert property (s_first(8'h9e) |=> flags_high_byte_store_op && !flags_high_byte_load_op)
    else $error("flag store not decoded");
  a_word_size: assert property (s_second |=> dec_valid && dec_word == $past(first[0]))
    else $error("size flag wrong");
  a_form_fields: assert property (s_second ##0 first inside {[8'h86:8'h8b]} |=>
    {dec_mode, dec_reg, dec_rm} == $past(byte_data) && dec_rm_is_reg == ($past(byte_data[7:6]) == 2'h3))
    else $error("form fields wrong");
  a_port_number: assert property (s_second ##0 first[7:4] == 4'he |=> dec_port == $past(byte_data) &&
    dec_class == ($past(first[1]) ? `CLS_PORT_OUT : `CLS_PORT_IN))
    else $error("port decode wrong");
  a_memory_only: assert property (s_second ##0 first inside {8'h8d, 8'hc4, 8'hc5} ##0 byte_data[7:6] == 2'h3
    |=> dec_illegal)
    else $error("register form accepted");
  a_stack_form: assert property (s_second ##0 ((first == 8'hff && byte_data[5:3] != 3'h6) ||
    (first == 8'h8f && byte_data[5:3] != 3'h0) || (first inside {8'h8c, 8'h8e} && byte_data[5])) |=> dec_illegal)
    else $error("bad middle field accepted");
  a_disp_none: assert property (dec_valid && dec_rm_is_reg |-> dec_disp_bytes == 2'h0)
    else $error("displacement on register form");
  a_hold_class: assert property (!$past(srst) && $changed(dec_class) |-> dec_valid)
    else $error("class changed without result");
endmodule // xfer_decoder_properties

`default_nettype wire

// ===== verification/fetch_model.sv
`timescale 1ns/1ps
`default_nettype none

module fetch_model
(
  input  wire logic       ref_clk,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data
);
  // Idle bus at time zero
  initial
  begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
  end

  // Present one byte from the next falling edge; it stays valid until the next put or rest
  task automatic put(input logic [7:0] b);
    @(negedge ref_clk);
    byte_valid = 1'b1;
    byte_data  = b;
  endtask

  // Release the bus; stale data is inverted so it never looks held
  task automatic rest();
    @(negedge ref_clk);
    byte_valid = 1'b0;
    byte_data  = ~byte_data;
  endtask
endmodule // fetch_model

`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "xfer_decoder_defs.vh"

module tb;
  logic              ref_clk = 1'b0;
  logic              srst    = 1'b1;
  logic              byte_valid, byte_ready, dec_valid, dec_word, dec_illegal, dec_rm_is_reg;
  logic [7:0]        byte_data, dec_port, b1;
  wire  [7:0]        ops;
  logic [`CLS_W-1:0] dec_class;
  logic [1:0]        dec_mode, dec_disp_bytes;
  logic [2:0]        dec_reg, dec_rm;
  logic [23:0]       r;
  logic              two;
  int                miscompares = 0;
  int                n_checks    = 0;
  // Opcode, next byte, class
  logic [23:0]       rows [20] = '{24'h884501, 24'h89c301, 24'h8a8602, 24'h8b0602, 24'h8cd804,
    24'h8e1803, 24'hff3605, 24'h8fc006, 24'h86cb07, 24'h871107, 24'he46008, 24'he5ff08, 24'he60009,
    24'he73f09, 24'h8d470a, 24'hc51e0b, 24'hc4840c, 24'hd7000d, 24'h9f000e, 24'h9e000f};
  logic [15:0]       bad [7] = '{16'h8e20, 16'hff06, 16'h8f08, 16'h8dc0, 16'hc5c0, 16'hc4ff, 16'h8c20};

  // Clock
  always #2 ref_clk = ~ref_clk;

  fetch_model feed_u (.ref_clk, .byte_valid, .byte_data);
  data_transfer_opcode_decoder dut_u (.ref_clk, .srst, .byte_valid, .byte_data, .byte_ready, .dec_valid,
    .dec_class, .dec_word, .dec_illegal, .dec_mode, .dec_reg, .dec_rm, .dec_rm_is_reg, .dec_disp_bytes,
    .dec_port, .transfer_op(ops[7]), .swap_op(ops[6]), .table_lookup_op(ops[5]),
    .effective_address_load_op(ops[4]), .far_pointer_data_seg_op(ops[3]),
    .far_pointer_extra_seg_op(ops[2]), .flags_high_byte_load_op(ops[1]), .flags_high_byte_store_op(ops[0]));

  function automatic logic [7:0] exp_ops(input logic [4:0] c);
    exp_ops = {c inside {[5'h01:5'h04]}, c == 5'h07, c == 5'h0d, c == 5'h0a, c == 5'h0b, c == 5'h0c,
      c == 5'h0e, c == 5'h0f};
  endfunction

  function automatic logic [1:0] exp_disp(input logic [7:0] f);
    exp_disp = (f[7:6] == 2'h1) ? 2'h1 : (f[7:6] == 2'h2 || (f[7:6] == 2'h0 && f[2:0] == 3'h6)) ? 2'h2 : 2'h0;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    n_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // Send one instruction and wait, bounded, for its result
  task automatic run_op(input logic [7:0] b0, input logic [7:0] b, input logic pair);
    int k;
    feed_u.put(b0);
    if (pair)
      feed_u.put(b);
    feed_u.rest();
    for (k = 0; k < 4 && dec_valid !== 1'b1; k++)
      @(negedge ref_clk);
    check(dec_valid, 1'b1);
    if (k == 4)
      complete_run();
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(negedge ref_clk);
    check({dec_valid, dec_class, dec_word, dec_illegal, dec_mode, dec_reg, dec_rm, dec_port, ops}, 0);
    check({dec_rm_is_reg, dec_disp_bytes, byte_ready}, 4'h1);
    $display("reset values done");
    srst = 1'b0;
    foreach (rows[i])
    begin
      r   = rows[i];
      b1  = r[15:8];
      two = r[4:0] < 5'h0d;
      run_op(r[23:16], b1, two);
      check(dec_class, r[4:0]);
      check(ops, exp_ops(r[4:0]));
      check({dec_word, dec_illegal}, {r[16], 1'b0});
      if (r[23:20] == 4'he)
        check(dec_port, b1);
      else if (two)
        check({dec_mode, dec_reg, dec_rm, dec_rm_is_reg, dec_disp_bytes}, {b1, b1[7:6] == 2'h3, exp_disp(b1)});
      else
        check({dec_mode, dec_reg, dec_rm, dec_port}, 0);
    end
    $display("table rows done");
    foreach (bad[i])
    begin
      run_op(bad[i][15:8], bad[i][7:0], 1'b1);
      check(dec_illegal, 1'b1);
    end
    run_op(8'h00, 8'h00, 1'b0);
    check({dec_illegal, dec_class}, 6'h20);
    $display("illegal forms done");
    feed_u.put(8'hd7);
    feed_u.put(8'h9e);
    check({dec_valid, ops}, 9'h120);
    feed_u.rest();
    check({dec_valid, ops}, 9'h101);
    @(negedge ref_clk);
    check(dec_valid, 1'b0);
    $display("back to back done");
    feed_u.put(8'h89);
    feed_u.rest();
    srst = 1'b1;
    @(negedge ref_clk);
    srst = 1'b0;
    check({dec_valid, dec_class}, 0);
    run_op(8'hd7, 8'h00, 1'b0);
    check({dec_class, ops, dec_illegal}, {5'h0d, 8'h20, 1'b0});
    $display("reset mid pair done");
    complete_run();
  end

  // Run length cap
  initial
  begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule // tb

bind data_transfer_opcode_decoder xfer_decoder_properties chk_u (.ref_clk, .srst, .byte_valid, .byte_data,
  .byte_ready, .dec_valid, .dec_class, .dec_word, .dec_illegal, .dec_mode, .dec_reg, .dec_rm, .dec_rm_is_reg,
  .dec_disp_bytes, .dec_port, .table_lookup_op, .flags_high_byte_load_op, .flags_high_byte_store_op);

`default_nettype wire
